// ==== core/bbm_pkg.sv ====
/*
  bbm_pkg: constants, flag carrier and shared decode helpers for the
  branch / bit-op / move decoder core.
  Assumes a single 100 MHz core clock and an APB register port.
*/
package bbm_pkg;

  // ==========================================================================
  // register map (byte addresses on the APB port)
  localparam logic [7:0]  BBM_OFF_CTRL  = 8'h00;  // bit0 run
  localparam logic [7:0]  BBM_OFF_IP    = 8'h04;  // instruction pointer, load while halted
  localparam logic [7:0]  BBM_OFF_FLAGS = 8'h08;  // apc, in-service, pointer, flags
  localparam logic [7:0]  BBM_OFF_SP    = 8'h0C;  // stack pointer
  localparam logic [7:0]  BBM_OFF_LC    = 8'h10;  // loop counters, 1 high / 0 low
  localparam logic [7:0]  BBM_OFF_ACC   = 8'h14;  // active working register
  localparam logic [15:0] BBM_IP_RST    = 16'h0000;
  localparam logic [15:0] BBM_SP_RST    = 16'h0000;
  localparam logic [15:0] BBM_WORD_RST  = 16'h0000;

  // ==========================================================================
  // storage sizes and pointer-control fields
  localparam int BBM_STK_DEPTH  = 16;
  localparam int BBM_DMEM_DEPTH = 32;
  localparam int BBM_MREG_DEPTH = 192;  // six modules of 32 words
  localparam int BBM_APC_INC    = 0;
  localparam int BBM_APC_DEC    = 1;
  localparam int BBM_APC_CLR    = 7;

  // ==========================================================================
  // opcode fields
  localparam logic [15:0] BBM_OP_CPL    = 16'h8A1A;
  localparam logic [15:0] BBM_OP_CPLC   = 16'hDA2A;
  localparam logic [7:0]  BBM_HI_ANDB   = 8'h9A;
  localparam logic [6:0]  BBM_OP_CMP    = 7'h78;
  localparam logic [6:0]  BBM_OP_CALL   = 7'h3D;
  localparam logic [3:0]  BBM_NIB_JUMP  = 4'hC;
  localparam logic [3:0]  BBM_NIB_STK   = 4'hD;
  localparam logic [3:0]  BBM_NIB_ACC   = 4'hA;
  localparam logic [3:0]  BBM_NIB_AREG  = 4'h9;
  localparam logic [3:0]  BBM_NIB_DP    = 4'hF;
  localparam logic [3:0]  BBM_NIB_PFX   = 4'hB;
  localparam logic [3:0]  BBM_NIB_BIT   = 4'h7;
  localparam logic [7:0]  BBM_SRC_AP    = 8'h08;
  localparam logic [7:0]  BBM_SRC_APC   = 8'h18;
  localparam logic [7:0]  BBM_SRC_PSF   = 8'h48;
  localparam logic [7:0]  BBM_SRC_ACC   = 8'h0A;
  localparam logic [7:0]  BBM_SRC_AACT  = 8'h1A;
  localparam logic [7:0]  BBM_SRC_IP    = 8'h0C;
  localparam logic [7:0]  BBM_SRC_STK   = 8'h0D;
  localparam logic [7:0]  BBM_SRC_SP    = 8'h1D;
  localparam logic [7:0]  BBM_SRC_STKI  = 8'h8D;
  localparam logic [6:0]  BBM_DST_AP    = 7'h08;
  localparam logic [6:0]  BBM_DST_APC   = 7'h18;
  localparam logic [6:0]  BBM_DST_PSF   = 7'h48;
  localparam logic [6:0]  BBM_DST_ACC   = 7'h0A;
  localparam logic [6:0]  BBM_DST_PUSH  = 7'h0D;
  localparam logic [6:0]  BBM_DST_SP    = 7'h1D;

  // processor flags, packed as the low nibble of the flag byte
  typedef struct packed {
    logic z;
    logic s;
    logic c;
    logic e;
  } bbm_flags_t;

  // two's-complement offset widened to a word
  function automatic logic [15:0] bbm_sext8(input logic [7:0] v);
    bbm_sext8 = {{8{v[7]}}, v};
  endfunction

  // low nibble of a specifier that names a peripheral module 0..5
  function automatic logic bbm_is_mod(input logic [3:0] low);
    bbm_is_mod = !low[3] && (low[2:0] <= 3'd5);
  endfunction

endpackage

// ==== core/bbm_core.sv ====
/*
  bbm_core: executes carry bit logic, complement, compare, call, count-down
  branch, jumps and the general move, one instruction per clock while run.
  Assumes program memory answers combinationally on instr for pm_addr, and
  an APB master on the register port.
*/
// The APB slave port and the register addresses are this design's own decisions.
// Notes on behaviour
// [RULE_01] carry becomes carry AND chosen working-register bit
// [RULE_02] call pushes next address, then loads pointer
// [RULE_03] short immediate call is relative to pointer
// [RULE_04] prefixed immediate call is absolute, prefix high
// [RULE_05] register-sourced call always absolute sixteen bits
// [RULE_06] compare sets equal flag on match, else clears
// [RULE_07] complement working register, update sign and zero
// [RULE_08] invert carry, nothing else changes
// [RULE_09] count-down branch decrements counter, branches if nonzero
// [RULE_10] plain jump loads relative or absolute target
// [RULE_11] jump target form chosen like the call
// [RULE_12] carry jumps on set, inverse on clear
// [RULE_13] zero jumps on set, inverse on clear
// [RULE_14] equal jumps on flag; software gives immediates only
// [RULE_15] sign jump only on set, else advance
// [RULE_16] move copies source, updates flags by destination
// [RULE_17] source top bit clear means literal byte
// [RULE_18] module codes pick registers, prefix picks upper half
// [RULE_19] plain working-register read steps pointer per control
// [RULE_20] stack-top read pops; variant also clears in-service
// [RULE_21] data pointer reads plain, post-increment, post-decrement
// [RULE_22] byte into word zero-fills unless prefix loaded
// [RULE_23] short offsets are signed and sign-extended
`timescale 1ns/1ps
module bbm_core import bbm_pkg::*; (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] instr,
  output logic      [15:0] pm_addr,
  output logic             in_service
);

  // ==========================================================================
  // state
  logic [15:0] ip_q;
  logic [15:0] sp_q;
  logic [15:0] lc_q    [2];
  logic [15:0] dp_q    [2];
  logic [15:0] acc_q   [16];
  logic [3:0]  ap_q;
  logic [7:0]  apc_q;
  bbm_flags_t  flags_q;
  logic        ins_q;
  logic [7:0]  pfx_data_q;
  logic [2:0]  pfx_idx_q;
  logic        pfx_vld_q;
  logic        run_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [15:0] stk_mem  [BBM_STK_DEPTH];
  logic [15:0] dmem     [BBM_DMEM_DEPTH];
  logic [15:0] mreg     [BBM_MREG_DEPTH];

  // ==========================================================================
  // instruction fields and class decode
  wire        f      = instr[15];
  wire [6:0]  op7    = instr[14:8];
  wire [7:0]  s8     = instr[7:0];
  wire        exec   = run_q;
  wire        is_cpl  = (instr == BBM_OP_CPL);
  wire        is_cplc = (instr == BBM_OP_CPLC);
  wire        is_andb = (instr[15:8] == BBM_HI_ANDB) && (instr[3:0] == BBM_NIB_ACC);
  wire        is_cmp  = (op7 == BBM_OP_CMP);
  wire        is_call = (op7 == BBM_OP_CALL);
  wire        is_count_down_branch = (op7[6:5] == 2'b10) && (op7[3:0] == BBM_NIB_STK);
  wire        is_jump = (op7[3:0] == BBM_NIB_JUMP);
  // the accumulator group and bit forms reuse move codes; they are not moves,
  // but a literal byte into the register stays a move whatever its low nibble
  wire        alu_grp = (op7[3:0] == BBM_NIB_ACC) &&
                        (op7[6:4] != 3'd0 || (f && s8[3:0] == BBM_NIB_ACC));
  wire        bit_grp = (op7[3:0] == BBM_NIB_BIT) || (f && s8[3:0] == BBM_NIB_BIT);
  wire        is_move = !(is_cmp || is_call || is_count_down_branch || is_jump || alu_grp || bit_grp);
  wire        src_rd  = exec && f && (is_move || is_cmp || is_jump || is_call || is_count_down_branch);

  // ==========================================================================
  // prefix use: register 0 gives a high byte, any other index the upper bank
  wire        pfx_hi  = pfx_vld_q && (pfx_idx_q == 3'd0);
  wire        bank    = pfx_vld_q && (pfx_idx_q != 3'd0);
  wire [15:0] acc_act = acc_q[ap_q];
  wire [7:0]  processor_flags     = {4'h0, flags_q};
  wire [7:0]  mreg_si = {s8[2:0], bank, s8[7:4]};                // see [RULE_18]
  wire        sdp_n   = s8[6];
  wire [15:0] sdp     = dp_q[sdp_n];
  wire [3:0]  ap_auto = apc_q[BBM_APC_INC] ? ap_q + 4'd1 :
                        apc_q[BBM_APC_DEC] ? ap_q - 4'd1 : ap_q;

  // source selection; only literal and byte registers are narrow
  logic [15:0] src_reg;
  logic        src8;
  always_comb begin
    src_reg = BBM_WORD_RST;
    src8    = 1'b0;
    if (!f) begin
      src_reg = {8'h00, s8};                                     // see [RULE_17]
      src8    = 1'b1;
    end else if (bbm_is_mod(s8[3:0])) begin
      src_reg = mreg[mreg_si];                                   // see [RULE_18]
    end else if (s8[3:0] == BBM_NIB_AREG) begin
      src_reg = acc_q[s8[7:4]];
    end else if (s8[3:0] == BBM_NIB_DP && !s8[7]) begin
      src_reg = (s8[5:4] == 2'b11) ? sdp : dmem[sdp[4:0]];       // see [RULE_21]
    end else if (s8[3:0] == BBM_NIB_STK && s8[7:5] == 3'b011) begin
      src_reg = lc_q[s8[4]];
    end else begin
      unique case (s8)
        BBM_SRC_AP:   begin src_reg = {12'h000, ap_q}; src8 = 1'b1; end
        BBM_SRC_APC:  begin src_reg = {8'h00, apc_q};  src8 = 1'b1; end
        BBM_SRC_PSF:  begin src_reg = {8'h00, processor_flags};    src8 = 1'b1; end
        BBM_SRC_ACC,
        BBM_SRC_AACT: src_reg = acc_act;
        BBM_SRC_IP:   src_reg = ip_q;
        BBM_SRC_STK,
        BBM_SRC_STKI: src_reg = stk_mem[sp_q[3:0]];
        BBM_SRC_SP:   src_reg = sp_q;
        default:      src_reg = BBM_WORD_RST;
      endcase
    end
  end

  // byte sources take the prefix byte on top or zero
  wire [7:0]  src_hi  = pfx_hi ? pfx_data_q : 8'h00;
  wire [15:0] src_val = src8 ? {src_hi, src_reg[7:0]} : src_reg;   // see [RULE_22]

  // ==========================================================================
  // branch decision and next pointer
  wire        rel     = !f && !pfx_hi;                           // see [RULE_03] [RULE_11]
  wire [15:0] rel_tgt = ip_q + bbm_sext8(s8);                    // see [RULE_23]
  wire [15:0] tgt     = rel ? rel_tgt : src_val;                 // see [RULE_04] [RULE_05]
  // condition index 0..7: always, Z, C, E, S, !Z, !C, !E
  wire [7:0]  cond_v  = {~flags_q.e, ~flags_q.c, ~flags_q.z, flags_q.s,
                         flags_q.e, flags_q.c, flags_q.z, 1'b1}; // see [RULE_14] [RULE_15]
  wire        jcond   = cond_v[op7[6:4]];                        // see [RULE_12] [RULE_13]
  wire [15:0] lc_dec  = lc_q[op7[4]] - 16'd1;
  wire        take    = (is_jump && jcond) || is_call ||         // see [RULE_10]
                        (is_count_down_branch && lc_dec != 16'd0);            // see [RULE_09]
  wire [15:0] ip_nxt  = ip_q + 16'd1;
  wire [15:0] ip_d    = take ? tgt : ip_nxt;

  // ==========================================================================
  // move destination decode
  wire        mv      = exec && is_move;
  wire [2:0]  dn      = op7[6:4];
  wire        ddp_n   = op7[6];
  wire [15:0] ddp     = dp_q[ddp_n];
  wire [15:0] ddp_adr = (op7[5:4] == 2'b01) ? ddp + 16'd1 :
                        (op7[5:4] == 2'b10) ? ddp - 16'd1 : ddp;
  wire        d_dpmem = mv && op7[3:0] == BBM_NIB_DP && op7[5:4] != 2'b11;
  wire        d_mod   = mv && bbm_is_mod(op7[3:0]);
  wire [7:0]  mreg_di = {op7[2:0], bank, 1'b0, dn};
  wire        d_push  = mv && op7 == BBM_DST_PUSH;
  wire        d_apc   = op7 == BBM_DST_APC;
  // flags after a write to the pointer, its control, or the register itself
  wire [15:0] sz_val  = (op7 == BBM_DST_AP) ? acc_q[src_val[3:0]] :
                        (d_apc && src_val[BBM_APC_CLR]) ? acc_q[0] :
                        d_apc ? acc_act : src_val;
  wire        sz_upd  = op7 == BBM_DST_AP || d_apc || op7 == BBM_DST_ACC;

  // ==========================================================================
  // apb slave: zero wait, one access cycle, registered answer
  wire        apb_set = psel && !penable;
  wire        apb_wr  = psel && penable && pwrite && pready_q;
  wire        hit     = paddr == BBM_OFF_CTRL || paddr == BBM_OFF_IP || paddr == BBM_OFF_FLAGS ||
                        paddr == BBM_OFF_SP || paddr == BBM_OFF_LC || paddr == BBM_OFF_ACC;
  wire [31:0] rd_mux  = (paddr == BBM_OFF_CTRL)  ? {31'h0000_0000, run_q} :
                        (paddr == BBM_OFF_IP)    ? {16'h0000, ip_q} :
                        (paddr == BBM_OFF_FLAGS) ? {8'h00, apc_q, 3'b000, ins_q, ap_q, processor_flags} :
                        (paddr == BBM_OFF_SP)    ? {16'h0000, sp_q} :
                        (paddr == BBM_OFF_LC)    ? {lc_q[1], lc_q[0]} :
                        (paddr == BBM_OFF_ACC)   ? {16'h0000, acc_act} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apb_set;
      pslverr_q <= apb_set && !hit;
      if (apb_set) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  assign prdata     = prdata_q;
  assign pready     = pready_q;
  assign pslverr    = pslverr_q;
  assign pm_addr    = ip_q;
  assign in_service = ins_q;

  // ==========================================================================
  // core registers; a pointer write while halted lets software place the core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ip_q       <= BBM_IP_RST;
      sp_q       <= BBM_SP_RST;
      lc_q[0]    <= BBM_WORD_RST;
      lc_q[1]    <= BBM_WORD_RST;
      dp_q[0]    <= BBM_WORD_RST;
      dp_q[1]    <= BBM_WORD_RST;
      for (int i = 0; i < 16; i++) begin
        acc_q[i] <= BBM_WORD_RST;
      end
      ap_q       <= 4'h0;
      apc_q      <= 8'h00;
      flags_q    <= '0;
      ins_q      <= 1'b0;
      pfx_data_q <= 8'h00;
      pfx_idx_q  <= 3'd0;
      pfx_vld_q  <= 1'b0;
      run_q      <= 1'b0;
    end else begin
      if (apb_wr && paddr == BBM_OFF_CTRL) begin
        run_q <= pwdata[0];
      end
      if (apb_wr && paddr == BBM_OFF_IP && !run_q) begin
        ip_q <= pwdata[15:0];
      end
      // in-service is preset only while halted, so it never races a pop
      if (apb_wr && paddr == BBM_OFF_FLAGS && !run_q) begin
        ins_q <= pwdata[12];
      end
      if (exec) begin
        ip_q      <= ip_d;
        pfx_vld_q <= 1'b0;                 // a prefix lives for one instruction
        if (is_andb) begin
          flags_q.c <= flags_q.c & acc_act[s8[7:4]];             // see [RULE_01]
        end
        if (is_cplc) begin
          flags_q.c <= ~flags_q.c;                               // see [RULE_08]
        end
        if (is_cpl) begin
          acc_q[ap_q] <= ~acc_act;                               // see [RULE_07]
          flags_q.s   <= ~acc_act[15];
          flags_q.z   <= acc_act == 16'hFFFF;
        end
        if (is_cmp) begin
          flags_q.e <= acc_act == src_val;                       // see [RULE_06]
        end
        if (is_count_down_branch) begin
          lc_q[op7[4]] <= lc_dec;                                // see [RULE_09]
        end
      end
      // side effects of reading a register source
      if (src_rd && s8 == BBM_SRC_ACC) begin
        ap_q <= ap_auto;                                         // see [RULE_19]
      end
      if (src_rd && (s8 == BBM_SRC_STK || s8 == BBM_SRC_STKI)) begin
        sp_q <= sp_q - 16'd1;                                    // see [RULE_20]
      end
      if (src_rd && s8 == BBM_SRC_STKI) begin
        ins_q <= 1'b0;                                           // see [RULE_20]
      end
      if (src_rd && s8[3:0] == BBM_NIB_DP && !s8[7] && s8[5:4] == 2'b01) begin
        dp_q[sdp_n] <= sdp + 16'd1;                              // see [RULE_21]
      end
      if (src_rd && s8[3:0] == BBM_NIB_DP && !s8[7] && s8[5:4] == 2'b10) begin
        dp_q[sdp_n] <= sdp - 16'd1;                              // see [RULE_21]
      end
      if (exec && (is_call || (is_move && op7 == BBM_DST_PUSH))) begin
        sp_q <= sp_q + 16'd1;                                    // see [RULE_02]
      end
      // destination writes; a written pointer beats its auto-step
      if (mv) begin
        if (sz_upd) begin
          flags_q.s <= sz_val[15];                               // see [RULE_16]
          flags_q.z <= sz_val == 16'h0000;
        end
        if (op7[3:0] == BBM_NIB_AREG) begin
          acc_q[{bank, dn}] <= src_val;
        end
        if (op7 == BBM_DST_ACC) begin
          acc_q[ap_q] <= src_val;
        end
        if (op7 == BBM_DST_AP) begin
          ap_q <= src_val[3:0];
        end
        if (d_apc) begin
          apc_q <= src_val[7:0];
          if (src_val[BBM_APC_CLR]) begin
            ap_q <= 4'h0;
          end
        end
        if (op7 == BBM_DST_PSF) begin
          flags_q.c <= src_val[1];                               // see [RULE_16]
          flags_q.e <= src_val[0];
        end
        if (op7[3:0] == BBM_NIB_PFX) begin
          pfx_data_q <= src_val[7:0];
          pfx_idx_q  <= dn;
          pfx_vld_q  <= 1'b1;
        end
        if (op7 == BBM_DST_SP) begin
          sp_q <= src_val;
        end
        if (op7[6:5] == 2'b11 && op7[3:0] == BBM_NIB_STK) begin
          lc_q[op7[4]] <= src_val;
        end
        if (op7[3:0] == BBM_NIB_DP) begin
          dp_q[ddp_n] <= (op7[5:4] == 2'b11) ? src_val : ddp_adr;
        end
      end
    end
  end

  // ==========================================================================
  // stack, data memory and module registers: no reset, contents are software's
  always_ff @(posedge pclk) begin
    if (exec && is_call) begin
      stk_mem[sp_q[3:0] + 4'd1] <= ip_nxt;                       // see [RULE_02]
    end
    if (d_push) begin
      stk_mem[sp_q[3:0] + 4'd1] <= src_val;
    end
    if (d_dpmem) begin
      dmem[ddp_adr[4:0]] <= src_val;
    end
    if (d_mod) begin
      mreg[mreg_di] <= src_val;
    end
  end

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_andb;
    exec && is_andb |=> flags_q.c == ($past(flags_q.c) & $past(acc_act[s8[7:4]]));
  endproperty
  a_andb: assert property (p_andb) else $error("carry and-bit wrong"); // see [RULE_01]

  property p_call;
    exec && is_call |=> sp_q == $past(sp_q) + 16'd1 && stk_mem[sp_q[3:0]] == $past(ip_q) + 16'd1;
  endproperty
  a_call: assert property (p_call) else $error("call push wrong"); // see [RULE_02]

  property p_rel;
    exec && (is_call || is_jump && instr[14:12] == 3'd0) && !f && !pfx_vld_q
      |=> ip_q == $past(ip_q) + {{8{$past(instr[7])}}, $past(instr[7:0])};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong"); // see [RULE_03]

  property p_abs;
    exec && (is_call || is_jump && instr[14:12] == 3'd0) && !f && pfx_vld_q && pfx_idx_q == 3'd0
      |=> ip_q == {$past(pfx_data_q), $past(instr[7:0])};
  endproperty
  a_abs: assert property (p_abs) else $error("prefixed target wrong"); // see [RULE_04]

  property p_cmp;
    exec && is_cmp && !f |=> flags_q.e == ($past(acc_act) == {$past(pfx_hi ? pfx_data_q : 8'h00),
                                                           $past(instr[7:0])});
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag wrong"); // see [RULE_06]

  property p_cplc;
    exec && is_cplc |=> flags_q.c != $past(flags_q.c) && ip_q == $past(ip_q) + 16'd1;
  endproperty
  a_cplc: assert property (p_cplc) else $error("carry invert wrong"); // see [RULE_08]

  property p_count_down_branch;
    exec && is_count_down_branch && lc_q[op7[4]] == 16'd1 |=> ip_q == $past(ip_q) + 16'd1;
  endproperty
  a_count_down_branch: assert property (p_count_down_branch) else $error("count-down fell wrong"); // see [RULE_09]

  property p_nojmp;
    exec && is_jump && op7[6:4] == 3'b010 && !flags_q.c |=> ip_q == $past(ip_q) + 16'd1;
  endproperty
  a_nojmp: assert property (p_nojmp) else $error("untaken jump moved"); // see [RULE_12]

  property p_popi;
    src_rd && s8 == BBM_SRC_STKI |=> !ins_q && sp_q == $past(sp_q) - 16'd1;
  endproperty
  a_popi: assert property (p_popi) else $error("stack-top read wrong"); // see [RULE_20]

  property p_apb;
    apb_set |=> pready ##1 !pready;
  endproperty
  a_apb: assert property (p_apb) else $error("apb answer timing wrong");

  c_call: cover property (exec && is_call);
  c_count_down_branch: cover property (exec && is_count_down_branch && take);
  c_cmpe: cover property (exec && is_cmp ##1 flags_q.e);
  c_pfx:  cover property (mv && op7[3:0] == BBM_NIB_PFX ##1 exec && is_jump);

endmodule

// ==== tb/bbm_pmem.sv ====
/*
  bbm_pmem: program memory answering instr for pm_addr at once.
  Assumes the bench fills it by the load task before run is set.
*/
`timescale 1ns/1ps
module bbm_pmem (
  input  wire logic [15:0] pm_addr,
  output logic      [15:0] instr
);
  // ==========================================================
  // storage, unused words hold the no-operation code
  logic [15:0] mem [0:255];
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hDA3A;
  end
  // outside the array a no-operation keeps the core harmless
  assign instr = (pm_addr < 16'h0100) ? mem[pm_addr[7:0]] : 16'hDA3A;
  task automatic load(input logic [7:0] a, input logic [15:0] w);
    mem[a] = w;
  endtask
endmodule

// ==== tb/branch_bitop_move_decoder_test.sv ====
/*
  branch_bitop_move_decoder_test: runs short programs, halts, reads state.
  Assumes the APB slave answers one cycle after setup; programs end in a self-jump.
*/
`timescale 1ns/1ps
module branch_bitop_move_decoder_test;
  import bbm_pkg::*;
  typedef struct packed {
    logic [31:0] exp;
    logic [31:0] msk;
    logic        err;
  } bbm_note_t;
  // ==========================================================
  // stimulus signals
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, in_service;
  logic [15:0] instr, pm_addr, v, nv;
  int          fails = 0, checked = 0;
  bbm_note_t   q[$];
  always #5 pclk = ~pclk;
  bbm_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr(instr), .pm_addr(pm_addr),
    .in_service(in_service));
  bbm_pmem pm (.pm_addr(pm_addr), .instr(instr));
  task automatic final_report();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================
  // apb master: holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                    input logic err);
    q.push_back('{e, m, err});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  // in_service is a level output; look at it mid-cycle where it is settled
  task automatic chk_ins(input logic e);
    @(negedge pclk);
    checked++;
    if (in_service !== e) begin
      fails++;
      $display("CHECK FAILED in_service expected %b seen %b", e, in_service);
    end
  endtask
  // monitor: each read answer is compared with the oldest note
  always @(posedge pclk) begin
    bbm_note_t nt;
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0) begin
      nt = q.pop_front();
      checked++;
      if (((prdata & nt.msk) !== nt.exp) || (pslverr !== nt.err)) begin
        fails++;
        $display("CHECK FAILED addr %h expected %h/%b seen %h/%b", paddr, nt.exp,
                 nt.err, prdata & nt.msk, pslverr);
      end
    end
  end
  // start at ip, run long enough to reach the closing self-jump, halt
  task automatic run(input logic [15:0] ip);
    apb(1'b1, BBM_OFF_IP, {16'h0000, ip});
    apb(1'b1, BBM_OFF_CTRL, 32'h0000_0001);
    apb(1'b1, BBM_OFF_IP, 32'h0000_0055);  // ignored while running
    repeat (40) @(posedge pclk);
    apb(1'b1, BBM_OFF_CTRL, 32'h0000_0000);
  endtask
  initial begin
    #200000;
    fails++;
    final_report();
  end
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(32'h880a));
    rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, BBM_OFF_FLAGS, 32'h0000_1000);
    rd(BBM_OFF_FLAGS, 32'h0000_1000, 32'h0000_1F0F, 1'b0);
    chk_ins(1'b1);
    // calls, count-down branch, every flag jump, negative offset, pop
    pm.load(8'h20, 16'h3D10);  // relative call
    pm.load(8'h30, 16'h0B00);
    pm.load(8'h31, 16'h3D40);  // absolute call, prefix high byte
    pm.load(8'h40, 16'h6D03);
    pm.load(8'h41, 16'h4D00);  // three passes
    pm.load(8'h42, 16'h2C05);  // c clear: fall through
    pm.load(8'h43, 16'h5C02);  // z clear: taken
    pm.load(8'h45, 16'h4C10);
    pm.load(8'h46, 16'h3C10);  // equal forms get immediates only
    pm.load(8'h47, 16'h7C02);
    pm.load(8'h49, 16'h1C05);
    pm.load(8'h4A, 16'h6C02);
    pm.load(8'h4C, 16'h0CF0);  // back by sixteen
    pm.load(8'h3C, 16'h8A8D);  // pop top of stack into acc, in-service off
    pm.load(8'h3D, 16'h0C00);
    run(16'h0020);
    rd(BBM_OFF_IP, 32'h0000_003D, 32'hFFFF_FFFF, 1'b0);
    rd(BBM_OFF_SP, 32'h0000_0001, 32'h0000_FFFF, 1'b0);
    rd(BBM_OFF_LC, 32'h0000_0000, 32'hFFFF_FFFF, 1'b0);
    rd(BBM_OFF_ACC, 32'h0000_0032, 32'hFFFF_FFFF, 1'b0);
    rd(BBM_OFF_FLAGS, 32'h0000_0000, 32'h0000_1F0F, 1'b0);
    chk_ins(1'b0);
    // complement, carry logic and compare on a random word
    v = 16'($urandom());
    nv = ~v;
    pm.load(8'h00, {8'h0B, v[15:8]});
    pm.load(8'h01, {8'h0A, v[7:0]});
    pm.load(8'h02, BBM_OP_CPL);
    pm.load(8'h03, BBM_OP_CPLC);
    pm.load(8'h04, {8'h0B, nv[15:8]});
    pm.load(8'h05, {8'h78, nv[7:0]});
    pm.load(8'h06, 16'h9A4A);
    pm.load(8'h07, 16'h0C00);
    run(16'h0000);
    rd(BBM_OFF_ACC, {16'h0000, nv}, 32'hFFFF_FFFF, 1'b0);
    rd(BBM_OFF_FLAGS, {28'h0, nv == 16'h0000, nv[15], nv[4], 1'b1},
       32'h0000_0F0F, 1'b0);
    rd(BBM_OFF_IP, 32'h0000_0007, 32'hFFFF_FFFF, 1'b0);
    repeat (3) @(posedge pclk);
    final_report();
  end
endmodule
